// file: dacu_ctrl.sv
// dac sample update, reset/standby sequencing, calibration and sample-rate strobe
//
// Overview of operation
// R1 - holding register loads at cs rise, 32 clocks
// R2 - processing register copies holding at strobe rise
// R3 - master writes between two strobe rising edges
// R4 - sample format: two's complement or straight binary
// R5 - reset outranks standby and serial activity
// R6 - in reset writes ignored, reads zero
// R7 - reset release restores all register defaults
// R8 - standby low makes output high impedance
// R9 - reset low, standby high drives reference
// R10 - power-on monitor acts as external reset
// R11 - config writes ignored, read zero in reset
// R12 - reference type writable only in standby
// R13 - clock source writable only in standby
// R14 - calibration launch only with standby high
// R15 - calibration flag zero at start, one at end
// R16 - wakeup holds reference level, then data
// R17 - controller power-up and wakeup sequence
// R18 - strobe is master clock over 256
// R19 - transition intervals strobe from low-speed clock
// R20 - strobe off while standby low; code runs it from the low-speed clock until the shutdown interval ends
// R21 - format bit: zero straight, one two's complement
// R22 - clock select defaults internal; zero selects external
// R23 - data register 16 bits, upper byte fixed
// R24 - reset and standby pins resynchronised first
`include "dacu_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dacu_ctrl
	import dacu_pkg::*;
#(
	parameter int unsigned WAKEUP_CYC = `DACU_WAKEUP_CYC,
	parameter int unsigned CALIBRATION_TIME_CYC = `DACU_CALIBRATION_TIME_CYC,
	parameter int unsigned SHUT_CYC = `DACU_SHUT_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control pins
	input wire logic async_reset_n,
	input wire logic standby_n,
	input wire logic supply_ok,
	input wire logic ext_master_clock_in,
	// serial framing
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [23:0] reg_rdata,
	// analog side
	output logic sync_out,
	output logic vout_hiz,
	output logic vout_ref,
	output logic [15:0] vout_code,
	output logic ref_type_sel
);
	logic wake_end;

	dacu_state_e state_r, state_nxt;
	logic arst_q1_r, arst_q2_r, stb_q1_r, stb_q2_r, por_q1_r, por_q2_r;
	logic rst_any, standby_s;
	logic [25:0] tmr_r;
	logic [22:0] cal_tmr_r;
	logic cal_busy_r, cal_done_r, cal_start;
	logic fmt_r, osc_sel_r, ref_r;
	logic [7:0] offset_r;
	logic [15:0] data_r, hold_r, proc_r;
	logic [5:0] sclk_cnt_r;
	logic sclk_q_r, cs_q_r, cs_rise;
	logic ext_q_r, int_tick, ext_tick, ls_tick, mclk_tick;
	logic [5:0] int_div_r;
	logic [11:0] ls_div_r;
	logic [6:0] sdiv_r;
	logic sync_q_r, sync_rise;
	logic wr_cfg, rd_cfg;

	function automatic logic [15:0] dacu_code(input logic [15:0] d, input logic twos);
		dacu_code = twos ? (d ^ `DACU_HALF_SCALE) : d;
	endfunction : dacu_code

	// pin resynchronisers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			arst_q1_r <= 1'b0;
			arst_q2_r <= 1'b0;
			stb_q1_r <= 1'b0;
			stb_q2_r <= 1'b0;
			por_q1_r <= 1'b0;
			por_q2_r <= 1'b0;
		end
		else
		begin
			arst_q1_r <= async_reset_n; // R24
			arst_q2_r <= arst_q1_r;
			stb_q1_r <= standby_n;
			stb_q2_r <= stb_q1_r;
			por_q1_r <= supply_ok;
			por_q2_r <= por_q1_r;
		end
	end

	assign rst_any = ~arst_q2_r | ~por_q2_r; // R10
	assign standby_s = stb_q2_r;
	assign wr_cfg = reg_wr && (reg_addr == `DACU_ADDR_CFG) && !rst_any; // R11
	assign rd_cfg = reg_rd && (reg_addr == `DACU_ADDR_CFG) && !rst_any;
	assign wake_end = state_r == DACU_ST_WAKE && state_nxt == DACU_ST_RUN;

	// sequencing state machine
	always_comb
	begin
		state_nxt = state_r;
		if (rst_any)
			state_nxt = DACU_ST_RESET; // R5
		else
		begin
			unique case (state_r)
				DACU_ST_RESET: state_nxt = standby_s ? DACU_ST_WAKE : DACU_ST_STANDBY;
				DACU_ST_STANDBY: if (standby_s) state_nxt = DACU_ST_WAKE;
				DACU_ST_WAKE:
				begin
					if (!standby_s)
						state_nxt = DACU_ST_SHUT;
					else if (tmr_r == 26'h0)
						state_nxt = DACU_ST_RUN; // R16
				end
				DACU_ST_RUN: if (!standby_s) state_nxt = DACU_ST_SHUT;
				DACU_ST_SHUT: if (tmr_r == 26'h0) state_nxt = DACU_ST_STANDBY;
				default: state_nxt = DACU_ST_RESET;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state_r <= DACU_ST_RESET;
		else
			state_r <= state_nxt;
	end

	// interval timer for wakeup and shutdown
	always_ff @(posedge clk)
	begin
		if (srst)
			tmr_r <= 26'h0;
		else if (state_nxt != state_r && state_nxt == DACU_ST_WAKE)
			tmr_r <= 26'(WAKEUP_CYC - 1); // R16
		else if (state_nxt != state_r && state_nxt == DACU_ST_SHUT)
			tmr_r <= 26'(SHUT_CYC - 1);
		else if (tmr_r != 26'h0)
			tmr_r <= tmr_r - 26'h1;
	end

	// configuration byte
	always_ff @(posedge clk)
	begin
		if (srst || rst_any)
		begin
			fmt_r <= `DACU_FMT_RST; // R7 R21
			osc_sel_r <= `DACU_OSC_RST; // R22
			ref_r <= `DACU_REF_RST;
		end
		else if (wr_cfg)
		begin
			fmt_r <= reg_wdata[`DACU_CFG_FMT]; // R21
			if (!standby_s)
			begin
				osc_sel_r <= reg_wdata[`DACU_CFG_OSC]; // R13 R22
				ref_r <= reg_wdata[`DACU_CFG_REF]; // R12
			end
		end
	end

	// reference type is latched toward the analog side only at wakeup from standby
	always_ff @(posedge clk)
	begin
		if (srst)
			ref_type_sel <= `DACU_REF_RST;
		else if (state_r == DACU_ST_STANDBY && standby_s)
			ref_type_sel <= ref_r; // R12
	end

	// calibration
	assign cal_start = wr_cfg && reg_wdata[`DACU_CFG_LAUNCH] && standby_s
		&& state_r == DACU_ST_RUN && !cal_busy_r; // R14
	always_ff @(posedge clk)
	begin
		if (srst || rst_any || state_r != DACU_ST_RUN)
		begin
			cal_busy_r <= 1'b0;
			cal_tmr_r <= 23'h0;
		end
		else if (cal_start)
		begin
			cal_busy_r <= 1'b1;
			cal_tmr_r <= 23'(CALIBRATION_TIME_CYC - 1);
		end
		else if (cal_busy_r)
		begin
			if (cal_tmr_r == 23'h0)
				cal_busy_r <= 1'b0;
			else
				cal_tmr_r <= cal_tmr_r - 23'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst || rst_any)
		begin
			cal_done_r <= 1'b0;
			offset_r <= `DACU_OFFSET_RST;
		end
		else if (cal_start)
			cal_done_r <= 1'b0; // R15
		else if ((cal_busy_r && cal_tmr_r == 23'h0) || wake_end)
		begin
			cal_done_r <= 1'b1; // R15
			offset_r <= `DACU_OFFSET_RST;
		end
		else if (rd_cfg)
			cal_done_r <= 1'b0;
	end

	// data register and serial frame check
	always_ff @(posedge clk)
	begin
		if (srst || rst_any)
			data_r <= 16'(`DACU_DATA_RST >> 8); // R23
		else if (reg_wr && reg_addr == `DACU_ADDR_DATA)
			data_r <= reg_wdata[15:0]; // R6 R23
	end

	assign cs_rise = spi_cs_n && !cs_q_r;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sclk_q_r <= 1'b0;
			cs_q_r <= 1'b1;
			sclk_cnt_r <= 6'h0;
		end
		else
		begin
			sclk_q_r <= spi_sclk;
			cs_q_r <= spi_cs_n;
			if (spi_cs_n)
				sclk_cnt_r <= 6'h0;
			else if (spi_sclk && !sclk_q_r && sclk_cnt_r != 6'h3f)
				sclk_cnt_r <= sclk_cnt_r + 6'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst || rst_any)
			hold_r <= 16'(`DACU_DATA_RST >> 8);
		else if ((cs_rise && sclk_cnt_r == `DACU_SCLK_COUNT) || wake_end)
			hold_r <= data_r; // R1 R16
	end

	// master clock ticks
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			int_div_r <= 6'h0;
			ls_div_r <= 12'h0;
			ext_q_r <= 1'b0;
		end
		else
		begin
			int_div_r <= int_tick ? 6'h0 : int_div_r + 6'h1;
			ls_div_r <= ls_tick ? 12'h0 : ls_div_r + 12'h1;
			ext_q_r <= ext_master_clock_in;
		end
	end
	assign int_tick = int_div_r == 6'(`DACU_INT_DIV - 1);
	assign ls_tick = ls_div_r == 12'(`DACU_LS_DIV - 1);
	assign ext_tick = ext_master_clock_in && !ext_q_r;

	always_comb
	begin
		unique case (state_r)
			DACU_ST_RUN: mclk_tick = osc_sel_r ? int_tick : ext_tick; // R18
			DACU_ST_WAKE, DACU_ST_SHUT: mclk_tick = ls_tick; // R19
			default: mclk_tick = 1'b0;
		endcase
	end

	// strobe: toggles every 128 ticks
	always_ff @(posedge clk)
	begin
		if (srst || state_r == DACU_ST_STANDBY || state_r == DACU_ST_RESET)
		begin
			sdiv_r <= 7'h0;
			sync_out <= 1'b0; // R20
		end
		else if (mclk_tick)
		begin
			sdiv_r <= sdiv_r + 7'h1;
			if (sdiv_r == 7'h7f)
				sync_out <= ~sync_out; // R18
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			sync_q_r <= 1'b0;
		else
			sync_q_r <= sync_out;
	end
	assign sync_rise = sync_out && !sync_q_r;

	always_ff @(posedge clk)
	begin
		if (srst || rst_any)
			proc_r <= 16'(`DACU_DATA_RST >> 8);
		else if (sync_rise)
			proc_r <= hold_r; // R2
		else if (wake_end)
			proc_r <= data_r; // R16
	end

	// analog output control
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			vout_hiz <= 1'b1;
			vout_ref <= 1'b0;
			vout_code <= `DACU_HALF_SCALE;
		end
		else
		begin
			vout_hiz <= !standby_s; // R8
			vout_ref <= standby_s && (rst_any || state_r != DACU_ST_RUN); // R9 R16
			vout_code <= dacu_code(proc_r, fmt_r); // R4
		end
	end

	// read port
	always_ff @(posedge clk)
	begin
		if (srst || !reg_rd || rst_any)
			reg_rdata <= 24'h0; // R6 R11
		else if (reg_addr == `DACU_ADDR_CFG)
			reg_rdata <= {8'h0, offset_r, fmt_r, 1'b1, osc_sel_r, 1'b1, 1'b0, ref_r, cal_done_r, 1'b0};
		else if (reg_addr == `DACU_ADDR_DATA)
			reg_rdata <= {8'(`DACU_DATA_RST >> 16), data_r};
		else
			reg_rdata <= 24'h0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	hold_load_a: assert property (cs_rise && sclk_cnt_r == 6'h20 && !rst_any |=> hold_r == $past(data_r)) // R1
		else $error("holding register not loaded");
	proc_copy_a: assert property (sync_rise && !rst_any |=> proc_r == $past(hold_r)) // R2
		else $error("processing register not copied");
	code_fmt_a: assert property (##1 vout_code == // R4
		($past(fmt_r) ? 16'($past(proc_r) + `DACU_HALF_SCALE) : $past(proc_r)))
		else $error("sample format wrong");
	rst_read_a: assert property (rst_any && reg_rd |=> reg_rdata == 24'h0) // R6
		else $error("read in reset not zero");
	rst_default_a: assert property (rst_any |=> osc_sel_r && !fmt_r && !ref_r && data_r == 16'h8000) // R7
		else $error("defaults not restored");
	hiz_out_a: assert property (!standby_s |=> vout_hiz) // R8
		else $error("output not high impedance");
	osc_lock_a: assert property (standby_s |=> $stable(osc_sel_r) || $past(rst_any)) // R13
		else $error("clock select changed in operation");
	cal_flag_a: assert property (cal_start |=> !cal_done_r && cal_busy_r) // R15
		else $error("calibration flag not cleared");
	cal_end_a: assert property (cal_busy_r && cal_tmr_r == 23'h0 && !rst_any |=> cal_done_r) // R15
		else $error("calibration flag not set at end");
	sync_off_a: assert property (state_r == DACU_ST_STANDBY |=> !sync_out) // R20
		else $error("strobe active in standby");

	wake_c: cover property (state_r == DACU_ST_WAKE ##1 state_r == DACU_ST_RUN);
	cal_c: cover property (cal_start);
	load_c: cover property (sync_rise && hold_r != proc_r);
endmodule : dacu_ctrl
`default_nettype wire

// file: dacu_defines.svh
// offsets, field positions, reset values and timing counts of the dac control block
`ifndef DACU_DEFINES_SVH
`define DACU_DEFINES_SVH
`define DACU_CLK_HZ 100000000
`define DACU_INT_MCLK_HZ 3000000
`define DACU_LS_CLK_HZ 32000
`define DACU_INT_DIV (`DACU_CLK_HZ / `DACU_INT_MCLK_HZ)
`define DACU_LS_DIV (`DACU_CLK_HZ / `DACU_LS_CLK_HZ)
`define DACU_WAKEUP_MS 440
`define DACU_CALIBRATION_TIME_MS 40
`define DACU_SHUT_US 1000
`define DACU_WAKEUP_CYC (`DACU_WAKEUP_MS * (`DACU_CLK_HZ / 1000))
`define DACU_CALIBRATION_TIME_CYC (`DACU_CALIBRATION_TIME_MS * (`DACU_CLK_HZ / 1000))
`define DACU_SHUT_CYC (`DACU_SHUT_US * (`DACU_CLK_HZ / 1000000))
`define DACU_SCLK_COUNT 6'h20
`define DACU_ADDR_CFG 8'h01
`define DACU_ADDR_DATA 8'h02
`define DACU_CFG_LAUNCH 0
`define DACU_CFG_CAL 1
`define DACU_CFG_REF 2
`define DACU_CFG_OSC 5
`define DACU_CFG_FMT 7
`define DACU_DATA_RST 24'h800008
`define DACU_OFFSET_RST 8'h80
`define DACU_FMT_RST 1'b0
`define DACU_OSC_RST 1'b1
`define DACU_REF_RST 1'b0
`define DACU_HALF_SCALE 16'h8000
`endif

// file: dacu_pkg.sv
// types of the dac control block
package dacu_pkg;
	typedef enum logic [2:0]
	{
		DACU_ST_RESET = 3'b000,
		DACU_ST_STANDBY = 3'b001,
		DACU_ST_WAKE = 3'b010,
		DACU_ST_RUN = 3'b011,
		DACU_ST_SHUT = 3'b100
	} dacu_state_e;
	typedef logic [23:0] dacu_word_t;
endpackage : dacu_pkg

// file: dacu_spi_model.sv
// serial master model driving chip select and serial clock frames
`timescale 1ns/1ps
`default_nettype none
module dacu_spi_model
(
	// clock
	input wire logic clk,
	// serial pins
	output logic cs_n,
	output logic sclk
);
	// idle: select pulled up, serial clock stands still low
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end

	// one frame with n serial clock rises
	task automatic frame(input int n);
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (n)
		begin
			repeat (2) @(posedge clk);
			sclk <= 1'b1;
			repeat (2) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		@(posedge clk);
	endtask : frame
endmodule : dacu_spi_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench of the dac control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	localparam int WK = 200;
	localparam int CT = 20;
	localparam int SH = 50;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic async_reset_n = 1'b0;
	logic standby_n = 1'b0;
	logic supply_ok = 1'b1;
	logic ext_clk = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [23:0] reg_wdata = 24'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [23:0] reg_rdata;
	logic sync_out, vout_hiz, vout_ref, ref_type_sel, cs_n, sclk;
	logic [15:0] vout_code, d1, d2, d3;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int ediv = 0;
	time r1, r2;
	int m_fmt, m_osc, m_ref, m_data, m_hold, m_proc;

	always #5 clk = ~clk;

	// external master clock: one tick every 34 cycles
	always @(posedge clk)
	begin
		ediv <= (ediv == 16) ? 0 : ediv + 1;
		if (ediv == 16)
			ext_clk <= ~ext_clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			fail_count++;
			wrap_up();
		end
	end

	dacu_spi_model dacu_spi_model_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk));

	dacu_ctrl #(.WAKEUP_CYC(WK), .CALIBRATION_TIME_CYC(CT), .SHUT_CYC(SH)) dacu_ctrl_inst (
		.clk(clk), .srst(srst), .async_reset_n(async_reset_n), .standby_n(standby_n),
		.supply_ok(supply_ok), .ext_master_clock_in(ext_clk), .spi_cs_n(cs_n), .spi_sclk(sclk),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sync_out(sync_out), .vout_hiz(vout_hiz), .vout_ref(vout_ref),
		.vout_code(vout_code), .ref_type_sel(ref_type_sel));

	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		if (async_reset_n && supply_ok && a == 8'h02)
			m_data = d[15:0];
		else if (async_reset_n && supply_ok && a == 8'h01)
		begin
			m_fmt = d[7];
			if (!standby_n)
			begin
				m_osc = d[5];
				m_ref = d[2];
			end
		end
	endtask : wr

	// behavioural model of the config byte and the sample path
	task automatic m_defaults();
		m_fmt = 0;
		m_osc = 1;
		m_ref = 0;
		m_data = 'h8000;
		m_hold = 'h8000;
		m_proc = 'h8000;
	endtask : m_defaults

	function automatic logic [23:0] m_cfg(input int cal);
		m_cfg = 24'('h8050 | (m_fmt << 7) | (m_osc << 5) | (m_ref << 2) | (cal << 1));
	endfunction : m_cfg

	function automatic logic [15:0] m_out();
		m_out = (m_fmt != 0) ? 16'(m_proc + 'h8000) : 16'(m_proc);
	endfunction : m_out

	task automatic sf(input int n);
		dacu_spi_model_inst.frame(n);
		if (n == 32)
			m_hold = m_data;
	endtask : sf

	// read and compare, data taken in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [23:0] e, input logic [23:0] m);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		`CHK(reg_rdata & m, e)
	endtask : rc

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	initial
	begin
		void'($urandom(19093));
		d1 = 16'($urandom);
		d2 = 16'($urandom);
		d3 = ~d2;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		wr(8'h01, 24'h0000a4);
		rc(8'h01, 24'h0, 24'hffffff);
		rc(8'h02, 24'h0, 24'hffffff);
		$display("test held reset done");
		async_reset_n <= 1'b1;
		m_defaults();
		repeat (4) @(posedge clk);
		rc(8'h01, m_cfg(0), 24'hffffff);
		rc(8'h02, 24'(m_data), 24'h00ffff);
		`CHK(vout_hiz, 1'b1)
		`CHK(sync_out, 1'b0)
		wr(8'h01, 24'h000004);
		rc(8'h01, m_cfg(0), 24'hffffff);
		wr(8'h02, {8'h00, d1});
		$display("test defaults done");
		standby_n <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK({vout_ref, vout_hiz}, 2'b10)
		repeat (WK + CT + 10) @(posedge clk);
		m_hold = m_data;
		m_proc = m_data;
		`CHK({vout_ref, vout_hiz}, 2'b00)
		`CHK(vout_code, m_out())
		`CHK(ref_type_sel, 1'(m_ref))
		rc(8'h01, m_cfg(1), 24'hffffff);
		rc(8'h01, m_cfg(0), 24'hffffff);
		wr(8'h01, 24'h000020);
		rc(8'h01, m_cfg(0), 24'hffffff);
		$display("test wakeup done");
		wr(8'h02, {8'h00, d2});
		@(posedge sync_out);
		sf(32);
		@(posedge sync_out);
		r1 = $time;
		m_proc = m_hold;
		repeat (3) @(posedge clk);
		`CHK(vout_code, m_out())
		wr(8'h02, {8'h00, d3});
		sf(31);
		@(posedge sync_out);
		r2 = $time;
		m_proc = m_hold;
		repeat (3) @(posedge clk);
		`CHK(vout_code, m_out())
		`CHK((r2 - r1 >= 87020 && r2 - r1 <= 87060), 1'b1)
		$display("test frames done");
		wr(8'h01, 24'h000080);
		@(posedge sync_out);
		m_proc = m_hold;
		repeat (3) @(posedge clk);
		`CHK(vout_code, m_out())
		wr(8'h01, 24'h000081);
		repeat (CT + 10) @(posedge clk);
		rc(8'h01, m_cfg(1), 24'hffffff);
		$display("test format and calibration done");
		async_reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK({vout_ref, vout_hiz}, 2'b10)
		rc(8'h01, 24'h0, 24'hffffff);
		async_reset_n <= 1'b1;
		m_defaults();
		repeat (5) @(posedge clk);
		rc(8'h01, m_cfg(0), 24'hffffff);
		supply_ok <= 1'b0;
		repeat (5) @(posedge clk);
		rc(8'h01, 24'h0, 24'hffffff);
		supply_ok <= 1'b1;
		m_defaults();
		repeat (WK + 20) @(posedge clk);
		rc(8'h01, m_cfg(1), 24'hffffff);
		$display("test reset priority done");
		standby_n <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(vout_hiz, 1'b1)
		repeat (SH + 20) @(posedge clk);
		`CHK(sync_out, 1'b0)
		wr(8'h01, 24'h000001);
		repeat (CT + 10) @(posedge clk);
		rc(8'h01, m_cfg(0), 24'hffffff);
		$display("test standby done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
